// ### common/subframe_timing_params.svh
// Register offsets, field positions and reset values of the sub-frame timing generator
`ifndef SUBFRAME_TIMING_PARAMS_SVH
`define SUBFRAME_TIMING_PARAMS_SVH
`define STG_OFS_CONTROL 8'h80
`define STG_OFS_AFE_BEGIN 8'h83
`define STG_OFS_AFE_FINISH 8'h84
`define STG_OFS_SEQ_BEGIN 8'h85
`define STG_OFS_SEQ_FINISH 8'h86
`define STG_OFS_CAP_BEGIN 8'h87
`define STG_BIT_ENABLE 0
`define STG_LEN_LSB 1
`define STG_LEN_MSB 16
`define STG_BIT_AUTO_DIS 23
`define STG_RST_CONTROL 24'h004E1E
`define STG_RST_LENGTH 16'h270F
`define STG_RST_AFE_BEGIN 16'h00D0
`define STG_RST_AFE_FINISH 16'h00D8
`define STG_RST_SEQ_BEGIN 16'h0020
`define STG_RST_SEQ_FINISH 16'h0028
`define STG_RST_CAP_BEGIN 16'h2454
`endif

// ### common/subframe_timing_pkg.sv
// Types shared by the sub-frame timing generator files
package subframe_timing_pkg;
	// Register access request from the host side
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [23:0] wdata;
	} reg_req_t;
	// Start and end count of one pulse window
	typedef struct packed {
		logic [15:0] begin_count;
		logic [15:0] finish_count;
	} pulse_window_t;
	// Counter run state
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} run_state_t;
endpackage

// ### core/pulse_window.sv
// Window comparator for one generated pulse
`timescale 1ns/100ps
`default_nettype none
module pulse_window (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [15:0] count_i,
	input wire subframe_timing_pkg::pulse_window_t win_i,
	output logic pulse_o
);
	logic pulse_q;
	wire in_window;
	// Active from begin count up to but not including finish count
	assign in_window = run_i && (count_i >= win_i.begin_count)
		&& (count_i < win_i.finish_count);
	// Registered pulse output
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			pulse_q <= 1'b0;
		else
			pulse_q <= in_window;
	end
	assign pulse_o = pulse_q;
endmodule
`default_nettype wire

// ### core/subframe_timing_generator.sv
// Sub-frame timing generator with register file and pulse outputs
`timescale 1ns/100ps
`default_nettype none
`include "subframe_timing_params.svh"
// Function
// - Counter runs only while control enable bit 0 is one.
// - Sub-frame length comes from control bits 16:1, reset 270Fh.
// - Bit 23 set stops automatic default filling of mask registers.
// - Data-path reset pulse begins at its begin count, reset D0h.
// - Reset pulse lasts finish minus begin generator clocks.
// - Data-path reset pulse ends at its finish count, reset D8h.
// - Sequencer interrupt pulse begins at its begin count, reset 20h.
// - Sequencer interrupt pulse ends at its finish count, reset 28h.
// - Reserved bits reset to zero, are written zero, read zero.
// - Capture pulse begins at capture begin count, reset 2454h.
module subframe_timing_generator (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire subframe_timing_pkg::reg_req_t req_i,
	output logic [23:0] rdata_o,
	output logic rvalid_o,
	output logic [15:0] subframe_clock_count_o,
	output logic afe_reset_pulse_o,
	output logic sequencer_irq_pulse_o,
	output logic capture_begin_o,
	output logic auto_mask_setup_o
);
	// ************************************************************
	// Register file
	// ************************************************************
	logic timing_generator_enable_q;
	logic auto_mask_setup_disable_q;
	logic [15:0] length_q;
	logic [15:0] afe_begin_q;
	logic [15:0] afe_finish_q;
	logic [15:0] seq_begin_q;
	logic [15:0] seq_finish_q;
	logic [15:0] cap_begin_q;
	logic [23:0] rdata_q;
	logic rvalid_q;
	wire [23:0] control_rd;
	logic [23:0] rdata_d;
	wire wr_control;
	wire wr_afe_begin;
	wire wr_afe_finish;
	wire wr_seq_begin;
	wire wr_seq_finish;
	wire wr_cap_begin;

	// Zero-fill a 16-bit count field into a read word
	function automatic logic [23:0] pad_word(input logic [15:0] count_field);
		return {8'h00, count_field};
	endfunction

	// Write strobes, one per mapped register; other addresses are ignored
	assign wr_control = req_i.wr && (req_i.addr == `STG_OFS_CONTROL);
	assign wr_afe_begin = req_i.wr && (req_i.addr == `STG_OFS_AFE_BEGIN);
	assign wr_afe_finish = req_i.wr && (req_i.addr == `STG_OFS_AFE_FINISH);
	assign wr_seq_begin = req_i.wr && (req_i.addr == `STG_OFS_SEQ_BEGIN);
	assign wr_seq_finish = req_i.wr && (req_i.addr == `STG_OFS_SEQ_FINISH);
	assign wr_cap_begin = req_i.wr && (req_i.addr == `STG_OFS_CAP_BEGIN);

	// Register writes; reserved bits are never stored
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			timing_generator_enable_q <= 1'b0;
			auto_mask_setup_disable_q <= 1'b0;
			length_q <= `STG_RST_LENGTH;
			afe_begin_q <= `STG_RST_AFE_BEGIN;
			afe_finish_q <= `STG_RST_AFE_FINISH;
			seq_begin_q <= `STG_RST_SEQ_BEGIN;
			seq_finish_q <= `STG_RST_SEQ_FINISH;
			cap_begin_q <= `STG_RST_CAP_BEGIN;
		end
		else
		begin
			if (wr_control)
			begin
				timing_generator_enable_q <= req_i.wdata[`STG_BIT_ENABLE];
				length_q <= req_i.wdata[`STG_LEN_MSB:`STG_LEN_LSB];
				auto_mask_setup_disable_q <= req_i.wdata[`STG_BIT_AUTO_DIS];
			end
			if (wr_afe_begin)
				afe_begin_q <= req_i.wdata[15:0];
			if (wr_afe_finish)
				afe_finish_q <= req_i.wdata[15:0];
			if (wr_seq_begin)
				seq_begin_q <= req_i.wdata[15:0];
			if (wr_seq_finish)
				seq_finish_q <= req_i.wdata[15:0];
			if (wr_cap_begin)
				cap_begin_q <= req_i.wdata[15:0];
		end
	end

	// Read data assembly with reserved bits zero
	assign control_rd = {auto_mask_setup_disable_q, 6'h00, length_q,
		timing_generator_enable_q};
	always_comb
	begin
		case (req_i.addr)
			`STG_OFS_CONTROL: rdata_d = control_rd;
			`STG_OFS_AFE_BEGIN: rdata_d = pad_word(afe_begin_q);
			`STG_OFS_AFE_FINISH: rdata_d = pad_word(afe_finish_q);
			`STG_OFS_SEQ_BEGIN: rdata_d = pad_word(seq_begin_q);
			`STG_OFS_SEQ_FINISH: rdata_d = pad_word(seq_finish_q);
			`STG_OFS_CAP_BEGIN: rdata_d = pad_word(cap_begin_q);
			default: rdata_d = 24'h000000;
		endcase
	end

	// Registered read answer one cycle after the request
	// Read data holds between reads so a slow host can still pick it up
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rdata_q <= 24'h000000;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= req_i.rd;
			if (req_i.rd)
				rdata_q <= rdata_d;
		end
	end
	assign rdata_o = rdata_q;
	assign rvalid_o = rvalid_q;

	// ************************************************************
	// Sub-frame counter
	// ************************************************************
	subframe_timing_pkg::run_state_t state_q;
	subframe_timing_pkg::run_state_t state_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	wire at_last;
	wire running;
	wire counting;

	// Last clock of the sub-frame; a zero length parks the count at zero
	assign at_last = (count_q >= length_q - 16'h0001) || (length_q == 16'h0000);
	assign running = (state_q == subframe_timing_pkg::ST_RUN);
	// Count only while run state and enable bit agree, so a clear stops at once
	assign counting = running && timing_generator_enable_q;

	// Run state follows the enable bit
	// Idle holds the count at zero until the next enable
	always_comb
	begin
		case (state_q)
			subframe_timing_pkg::ST_IDLE:
				state_d = timing_generator_enable_q ? subframe_timing_pkg::ST_RUN
					: subframe_timing_pkg::ST_IDLE;
			subframe_timing_pkg::ST_RUN:
				state_d = timing_generator_enable_q ? subframe_timing_pkg::ST_RUN
					: subframe_timing_pkg::ST_IDLE;
			default: state_d = subframe_timing_pkg::ST_IDLE;
		endcase
	end

	// Count wraps to zero after the programmed length
	assign count_d = !counting ? 16'h0000 : (at_last ? 16'h0000 : count_q + 16'h0001);

	// Counter state
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			state_q <= subframe_timing_pkg::ST_IDLE;
			count_q <= 16'h0000;
		end
		else
		begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end
	assign subframe_clock_count_o = count_q;

	// ************************************************************
	// Pulse generation
	// ************************************************************
	subframe_timing_pkg::pulse_window_t afe_win;
	subframe_timing_pkg::pulse_window_t seq_win;
	subframe_timing_pkg::pulse_window_t cap_win;
	assign afe_win = '{begin_count: afe_begin_q, finish_count: afe_finish_q};
	assign seq_win = '{begin_count: seq_begin_q, finish_count: seq_finish_q};
	// A begin count of FFFFh is never reached, so the wrapped finish is harmless
	assign cap_win = '{begin_count: cap_begin_q,
		finish_count: cap_begin_q + 16'h0001};

	// Data-path reset pulse
	pulse_window u_afe (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.run_i(counting),
		.count_i(count_q),
		.win_i(afe_win),
		.pulse_o(afe_reset_pulse_o)
	);
	// Sequencer interrupt pulse
	pulse_window u_seq (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.run_i(counting),
		.count_i(count_q),
		.win_i(seq_win),
		.pulse_o(sequencer_irq_pulse_o)
	);
	// Capture start marker, one clock wide
	pulse_window u_cap (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.run_i(counting),
		.count_i(count_q),
		.win_i(cap_win),
		.pulse_o(capture_begin_o)
	);

	// Automatic mask setup stays on until software disables it
	assign auto_mask_setup_o = !auto_mask_setup_disable_q;
endmodule
`default_nettype wire

// ### tb/subframe_timing_properties.sv
// Checker for the sub-frame timing generator ports
`timescale 1ns/100ps
`default_nettype none
module subframe_timing_properties (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire subframe_timing_pkg::reg_req_t req_i,
	input wire logic [23:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic [15:0] subframe_clock_count_o,
	input wire logic afe_reset_pulse_o,
	input wire logic sequencer_irq_pulse_o,
	input wire logic capture_begin_o,
	input wire logic auto_mask_setup_o
);
	logic [23:0] ctl_q;
	logic [15:0] sh_q [5];
	logic [15:0] cnt;
	logic [7:0] idx;
	logic [23:0] exp_rd;
	// Shadow decode and expected read word
	assign cnt = subframe_clock_count_o;
	assign idx = req_i.addr - 8'h83;
	assign exp_rd = (req_i.addr == 8'h80) ? ctl_q : (idx < 8'h05) ? {8'h00, sh_q[idx[2:0]]} : 24'h0;
	// Shadow of the register file, reserved bits dropped
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			ctl_q <= 24'h004E1E;
			sh_q <= '{16'h00D0, 16'h00D8, 16'h0020, 16'h0028, 16'h2454};
		end
		else if (req_i.wr && req_i.addr == 8'h80)
			ctl_q <= req_i.wdata & 24'h81FFFF;
		else if (req_i.wr && idx < 8'h05)
			sh_q[idx[2:0]] <= req_i.wdata[15:0];
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_run; ctl_q[0] && $past(ctl_q[0]); endsequence
	sequence s_live; $past(ctl_q[0]) && $past(ctl_q[0], 2); endsequence
	property p_step; s_run ##0 cnt + 1 < ctl_q[16:1] |=> cnt == $past(cnt) + 1; endproperty
	property p_wrap; s_run ##0 cnt + 1 == ctl_q[16:1] |=> cnt == 16'h0000; endproperty
	property p_stop; !ctl_q[0] |=> cnt == 16'h0000; endproperty
	property p_afe; s_live |-> afe_reset_pulse_o ==
		($past(cnt) >= $past(sh_q[0]) && $past(cnt) < $past(sh_q[1])); endproperty
	property p_seq; s_live |-> sequencer_irq_pulse_o ==
		($past(cnt) >= $past(sh_q[2]) && $past(cnt) < $past(sh_q[3])); endproperty
	property p_cap; s_live |-> capture_begin_o == ($past(cnt) == $past(sh_q[4])); endproperty
	property p_quiet; !$past(ctl_q[0]) |-> !afe_reset_pulse_o && !sequencer_irq_pulse_o
		&& !capture_begin_o; endproperty
	property p_auto; auto_mask_setup_o == !ctl_q[23]; endproperty
	property p_read; req_i.rd |=> rvalid_o && rdata_o == $past(exp_rd); endproperty
	a_step: assert property (p_step) else $error("count step");
	a_wrap: assert property (p_wrap) else $error("count wrap");
	a_stop: assert property (p_stop) else $error("count runs");
	a_afe: assert property (p_afe) else $error("afe window");
	a_seq: assert property (p_seq) else $error("seq window");
	a_cap: assert property (p_cap) else $error("capture");
	a_quiet: assert property (p_quiet) else $error("pulse while stopped");
	a_auto: assert property (p_auto) else $error("auto mask");
	a_read: assert property (p_read) else $error("read word");
endmodule
bind subframe_timing_generator subframe_timing_properties i_chk (.mclk_i, .rst_i, .req_i,
	.rdata_o, .rvalid_o, .subframe_clock_count_o, .afe_reset_pulse_o, .sequencer_irq_pulse_o,
	.capture_begin_o, .auto_mask_setup_o);
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the sub-frame timing generator
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	subframe_timing_pkg::reg_req_t req_i = '0;
	logic [23:0] rdata_o;
	logic rvalid_o, afe, seq, cap, auto;
	logic [15:0] cnt;
	int err_total = 0;
	int checks = 0;
	subframe_timing_generator i_dut (.mclk_i, .rst_i, .req_i, .rdata_o, .rvalid_o,
		.subframe_clock_count_o(cnt), .afe_reset_pulse_o(afe), .sequencer_irq_pulse_o(seq),
		.capture_begin_o(cap), .auto_mask_setup_o(auto));
	initial forever #20 mclk_i = ~mclk_i;
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("mismatches %0d of %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tick;
		@(posedge mclk_i);
		#1;
	endtask
	// Request held one edge, then one idle edge
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		req_i = '{1'b1, 1'b0, a, d};
		tick;
		req_i = '0;
		tick;
	endtask
	task automatic rd(input logic [7:0] a, input logic [23:0] exp);
		req_i = '{1'b0, 1'b1, a, 24'h0};
		tick;
		req_i = '0;
		chk({23'h000000, rvalid_o}, 24'h000001);
		chk(rdata_o, exp);
		tick;
		chk({23'h000000, rvalid_o}, 24'h000000);
	endtask
	task automatic t_reset;
		rd(8'h80, 24'h004E1E);
		rd(8'h83, 24'h0000D0);
		rd(8'h84, 24'h0000D8);
		rd(8'h85, 24'h000020);
		rd(8'h86, 24'h000028);
		rd(8'h87, 24'h002454);
		rd(8'h81, 24'h000000);
		chk({23'h000000, auto}, 24'h000001);
	endtask
	// Short windows, reserved bits written high
	task automatic t_write;
		wr(8'h83, 24'hFF0003);
		rd(8'h83, 24'h000003);
		wr(8'h84, 24'h000005);
		wr(8'h85, 24'h000006);
		wr(8'h86, 24'h000007);
		wr(8'h87, 24'h000008);
		rd(8'h87, 24'h000008);
		wr(8'h80, 24'hFE0014);
		rd(8'h80, 24'h800014);
		chk({23'h000000, auto}, 24'h000000);
	endtask
	// Three frames of ten clocks, then stop
	task automatic t_run;
		int na = 0;
		int ns = 0;
		int nc = 0;
		wr(8'h80, 24'h000015);
		tick;
		repeat (30)
		begin
			tick;
			na += int'(afe);
			ns += int'(seq);
			nc += int'(cap);
		end
		chk(na[23:0], 24'h000006);
		chk(ns[23:0], 24'h000003);
		chk(nc[23:0], 24'h000003);
		wr(8'h80, 24'h000014);
		repeat (3) tick;
		chk({cnt, 5'h00, afe, seq, cap}, 24'h000000);
	endtask
	// Default length, wait for the wrap
	task automatic t_long;
		int n = 0;
		wr(8'h80, 24'h004E1F);
		while (cnt !== 16'h270E && n < 10100)
		begin
			tick;
			n++;
		end
		if (n == 10100)
		begin
			err_total++;
			results;
		end
		tick;
		chk({8'h00, cnt}, 24'h000000);
	endtask
	// Reset in mid-run returns count, pulses and registers to reset state
	task automatic t_midreset;
		rst_i = 1'b1;
		repeat (2) tick;
		rst_i = 1'b0;
		chk({cnt, 5'h00, afe, seq, cap}, 24'h000000);
		t_reset;
	endtask
	initial
	begin
		repeat (3) @(posedge mclk_i);
		#1 rst_i = 1'b0;
		t_reset;
		t_write;
		t_run;
		t_long;
		t_midreset;
		results;
	end
endmodule
`default_nettype wire
